/* src/sac_adc_ctrl.sv */
/*
  Control and configuration of a SAR converter reached through two special-function registers.
  Assumes synchronous strobes from the processor, synchronous trigger inputs, and an analog core that
  starts on core_start, converts on sar_tick and reports core_done with its 10-bit result.
*/
// Overview of operation
// - Enable bit 0 keeps the converter shut down unless burst is on; 1 makes it ready.
// - Burst enable bit turns burst operation on at 1, off at 0.
// - Done flag sets when a conversion or burst ends; software clears it.
// - Window flag sets when the result lies inside the thresholds; software clears it.
// - Source 000 starts a conversion when software writes 1 to busy.
// - Sources 001/010/011 use timer 0/2/3 overflows; 1xx uses pin rising edge.
// - SAR clock is the source clock divided by divider field plus one.
// - Divider source is system clock, or the low-power oscillator in burst.
// - Eight-bit mode bit selects 10-bit conversions at 0, 8-bit at 1.
// - Track mode 0 starts converting right after the start signal.
// - Track mode 1 tracks three SAR clocks before converting.
// - Gain bit selects 0.5 at 0 and one at 1.
// - In eight-bit mode the two low result bits are zero; low byte reads zero.
// - Delayed tracking adds three SAR clocks before every conversion.
`include "sac_cfg.svh"
module sac_adc_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic timer0_overflow,
  input wire logic timer2_overflow,
  input wire logic timer3_overflow,
  input wire logic external_convert_pin,
  input wire logic lpo_tick,
  input wire sac_pkg::sac_result_type window_lower_bound,
  input wire sac_pkg::sac_result_type window_upper_bound,
  input wire logic core_done,
  input wire sac_pkg::sac_result_type core_result,
  output logic core_powered,
  output logic core_start,
  output logic core_track,
  output logic sar_tick,
  output logic eight_bit_mode,
  output logic gain_select,
  output logic divider_source_lpo,
  output logic [7:0] result_high_byte,
  output logic [7:0] result_low_byte
);
  import sac_pkg::*;

  function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] target);
    sfr_hit = (addr == target);
  endfunction

  sac_tick_if tif();

  sac_sar_timer #(.TRACK_TICKS(`SAC_TRACK_TICKS)) u_timer (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .tif(tif)
  );

  logic [7:0] config_reg, config_next;
  logic converter_enable_reg, converter_enable_next;
  logic burst_mode_enable_reg, burst_mode_enable_next;
  logic conversion_done_flag_reg, conversion_done_flag_next;
  logic window_match_flag_reg, window_match_flag_next;
  logic [2:0] start_source_select_reg, start_source_select_next;
  sac_state_type state_reg, state_next;
  sac_result_type result_reg, result_next;
  logic win_pend_reg, win_pend_next;
  logic pin_prev_reg;
  logic core_powered_reg, core_powered_next;
  logic core_start_reg, core_start_next;
  logic core_track_reg, core_track_next;
  logic [7:0] rdata_reg, rdata_next;
  logic ctl_wr, cfg_wr, sw_start, trigger, accepted, in_window;

  always_comb begin
    ctl_wr = sfr_wr && sfr_hit(sfr_addr, `SAC_CONTROL_ADDR);
    cfg_wr = sfr_wr && sfr_hit(sfr_addr, `SAC_CONFIG_ADDR);
    sw_start = ctl_wr && sfr_wdata[`SAC_CTL_BUSY];
    unique case (start_source_select_reg)
      `SAC_SRC_SOFTWARE: trigger = sw_start;
      `SAC_SRC_TIMER0: trigger = timer0_overflow;
      `SAC_SRC_TIMER2: trigger = timer2_overflow;
      `SAC_SRC_TIMER3: trigger = timer3_overflow;
      default: trigger = external_convert_pin && !pin_prev_reg;
    endcase
    // Starts during a conversion are dropped; relies on the source spacing starts out
    accepted = trigger && (converter_enable_reg || burst_mode_enable_reg) && state_reg == SAC_IDLE;
    in_window = (result_reg > window_lower_bound) && (result_reg < window_upper_bound);
  end

  always_comb begin
    config_next = cfg_wr ? sfr_wdata : config_reg;
    converter_enable_next = ctl_wr ? sfr_wdata[`SAC_CTL_ENABLE] : converter_enable_reg;
    burst_mode_enable_next = ctl_wr ? sfr_wdata[`SAC_CTL_BURST] : burst_mode_enable_reg;
    start_source_select_next = ctl_wr ? sfr_wdata[`SAC_CTL_SRC_HI:`SAC_CTL_SRC_LO] : start_source_select_reg;
    state_next = state_reg;
    result_next = result_reg;
    win_pend_next = 1'b0;
    core_start_next = 1'b0;
    tif.track_go = 1'b0;
    unique case (state_reg)
      SAC_IDLE: begin
        if (accepted) begin
          if (config_reg[`SAC_CFG_TRACK]) begin
            state_next = SAC_TRACK;
            tif.track_go = 1'b1;
          end else begin
            state_next = SAC_CONVERT;
            core_start_next = 1'b1;
          end
        end
      end
      SAC_TRACK: begin
        if (tif.track_done) begin
          state_next = SAC_CONVERT;
          core_start_next = 1'b1;
        end
      end
      SAC_CONVERT: begin
        if (core_done) begin
          state_next = SAC_IDLE;
          // Eight-bit results drop the two low bits
          result_next = config_reg[`SAC_CFG_EIGHT] ? {core_result[9:2], 2'b00} : core_result;
          win_pend_next = 1'b1;
        end
      end
    endcase
    // Hardware set wins over a software write in the same cycle
    conversion_done_flag_next = (state_reg == SAC_CONVERT && core_done) ? 1'b1 :
      (ctl_wr ? sfr_wdata[`SAC_CTL_DONE] : conversion_done_flag_reg);
    window_match_flag_next = (win_pend_reg && in_window) ? 1'b1 :
      (ctl_wr ? sfr_wdata[`SAC_CTL_WMATCH] : window_match_flag_reg);
    // Burst powers the core only while a conversion is under way
    core_powered_next = converter_enable_next || (burst_mode_enable_next && state_next != SAC_IDLE);
    core_track_next = (state_next == SAC_TRACK);
    rdata_next = rdata_reg;
    if (sfr_rd) begin
      if (sfr_hit(sfr_addr, `SAC_CONTROL_ADDR)) begin
        rdata_next = {converter_enable_reg, burst_mode_enable_reg, conversion_done_flag_reg,
                      state_reg != SAC_IDLE, window_match_flag_reg, start_source_select_reg};
      end else if (sfr_hit(sfr_addr, `SAC_CONFIG_ADDR)) begin
        rdata_next = config_reg;
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      config_reg <= `SAC_CONFIG_RESET;
      converter_enable_reg <= 1'b0;
      burst_mode_enable_reg <= 1'b0;
      conversion_done_flag_reg <= 1'b0;
      window_match_flag_reg <= 1'b0;
      start_source_select_reg <= 3'h0;
      state_reg <= SAC_IDLE;
      result_reg <= '0;
      win_pend_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
      core_powered_reg <= 1'b0;
      core_start_reg <= 1'b0;
      core_track_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else if (ce) begin
      config_reg <= config_next;
      converter_enable_reg <= converter_enable_next;
      burst_mode_enable_reg <= burst_mode_enable_next;
      conversion_done_flag_reg <= conversion_done_flag_next;
      window_match_flag_reg <= window_match_flag_next;
      start_source_select_reg <= start_source_select_next;
      state_reg <= state_next;
      result_reg <= result_next;
      win_pend_reg <= win_pend_next;
      pin_prev_reg <= external_convert_pin;
      core_powered_reg <= core_powered_next;
      core_start_reg <= core_start_next;
      core_track_reg <= core_track_next;
      rdata_reg <= rdata_next;
    end
  end

  assign tif.burst_src = burst_mode_enable_reg;
  assign tif.lpo_tick = lpo_tick;
  assign tif.divider = config_reg[`SAC_CFG_DIV_HI:`SAC_CFG_DIV_LO];
  assign sfr_rdata = rdata_reg;
  assign core_powered = core_powered_reg;
  assign core_start = core_start_reg;
  assign core_track = core_track_reg;
  assign sar_tick = tif.tick;
  assign eight_bit_mode = config_reg[`SAC_CFG_EIGHT];
  assign gain_select = config_reg[`SAC_CFG_GAIN];
  assign divider_source_lpo = burst_mode_enable_reg;
  assign result_high_byte = result_reg[9:2];
  assign result_low_byte = {result_reg[1:0], 6'h00};

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  done_flag_set_a: assert property (ce && state_reg == SAC_CONVERT && core_done |=> conversion_done_flag_reg)
    else $error("Done flag not set after conversion");
  window_flag_set_a: assert property (ce && win_pend_reg && in_window |=> window_match_flag_reg)
    else $error("Window flag not set for in-window result");
  window_once_a: assert property (ce && win_pend_reg |=> !win_pend_reg)
    else $error("Window compare repeated");
  sw_start_a: assert property (ce && state_reg == SAC_IDLE && converter_enable_reg && sw_start
    && start_source_select_reg == `SAC_SRC_SOFTWARE && !config_reg[`SAC_CFG_TRACK] |=> core_start && state_reg == SAC_CONVERT)
    else $error("Software start not taken");
  timer_start_a: assert property (ce && state_reg == SAC_IDLE && converter_enable_reg && timer2_overflow
    && start_source_select_reg == `SAC_SRC_TIMER2 && config_reg[`SAC_CFG_TRACK] |=> core_track && !core_start)
    else $error("Timer start did not enter tracking");
  disabled_ignore_a: assert property (ce && state_reg == SAC_IDLE && !converter_enable_reg && !burst_mode_enable_reg
    |=> state_reg == SAC_IDLE) else $error("Trigger taken while disabled");
  eight_bit_low_a: assert property (ce && state_reg == SAC_CONVERT && core_done && eight_bit_mode
    |=> result_low_byte == 8'h00) else $error("Low byte not zero in eight-bit mode");
  shutdown_a: assert property (ce && !converter_enable_next && !burst_mode_enable_next |=> !core_powered)
    else $error("Core powered while disabled");

  cover_burst_c: cover property (burst_mode_enable_reg && state_reg == SAC_CONVERT && core_done);
  cover_delayed_c: cover property (core_track ##[1:200] core_start);
  cover_window_c: cover property (win_pend_reg && in_window);
  cover_pin_c: cover property (start_source_select_reg[2] && accepted);
endmodule

/* src/sac_cfg.svh */
/*
  Register offsets, field positions, reset values and timing counts of the converter control block.
  Assumes inclusion by bare name from the design modules.
*/
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH
`define SAC_CONFIG_ADDR 8'h97
`define SAC_CONTROL_ADDR 8'he8
`define SAC_CONFIG_RESET 8'hf8
`define SAC_CONTROL_RESET 8'h00
`define SAC_CTL_ENABLE 7
`define SAC_CTL_BURST 6
`define SAC_CTL_DONE 5
`define SAC_CTL_BUSY 4
`define SAC_CTL_WMATCH 3
`define SAC_CTL_SRC_HI 2
`define SAC_CTL_SRC_LO 0
`define SAC_CFG_DIV_HI 7
`define SAC_CFG_DIV_LO 3
`define SAC_CFG_EIGHT 2
`define SAC_CFG_TRACK 1
`define SAC_CFG_GAIN 0
`define SAC_TRACK_TICKS 3
`define SAC_SRC_SOFTWARE 3'h0
`define SAC_SRC_TIMER0 3'h1
`define SAC_SRC_TIMER2 3'h2
`define SAC_SRC_TIMER3 3'h3
`endif

/* src/sac_pkg.sv */
/*
  Types shared by the converter control modules.
  Assumes the constants header is available on the include path.
*/
package sac_pkg;
  typedef enum logic [1:0] {SAC_IDLE, SAC_TRACK, SAC_CONVERT} sac_state_type;
  typedef logic [4:0] sac_div_type;
  typedef logic [9:0] sac_result_type;
endpackage

/* src/sac_sar_timer.sv */
/*
  SAR conversion clock divider and delayed-tracking counter.
  Assumes lpo_tick is a one-cycle enable marking each low-power oscillator edge.
*/
`include "sac_cfg.svh"
module sac_sar_timer #(
  parameter int TRACK_TICKS = `SAC_TRACK_TICKS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  sac_tick_if.timer tif
);
  import sac_pkg::*;

  // The tracking count is four bits wide and must reach zero from its load value
  if (TRACK_TICKS < 1 || TRACK_TICKS > 15) begin : gen_track_check
    $error("TRACK_TICKS out of range");
  end

  sac_div_type div_cnt_reg, div_cnt_next;
  logic tick_reg, tick_next;
  logic [3:0] track_cnt_reg, track_cnt_next;
  logic track_done_reg, track_done_next;
  logic src_tick;

  always_comb begin
    src_tick = tif.burst_src ? tif.lpo_tick : 1'b1;
    div_cnt_next = div_cnt_reg;
    tick_next = 1'b0;
    if (src_tick) begin
      if (div_cnt_reg >= tif.divider) begin
        div_cnt_next = '0;
        tick_next = 1'b1;
      end else begin
        div_cnt_next = div_cnt_reg + 5'h01;
      end
    end
    track_cnt_next = track_cnt_reg;
    track_done_next = 1'b0;
    if (tif.track_go) begin
      track_cnt_next = 4'(TRACK_TICKS);
    end else if (tick_reg && track_cnt_reg != 4'h0) begin
      track_cnt_next = track_cnt_reg - 4'h1;
      track_done_next = (track_cnt_reg == 4'h1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt_reg <= '0;
      tick_reg <= 1'b0;
      track_cnt_reg <= 4'h0;
      track_done_reg <= 1'b0;
    end else if (ce) begin
      div_cnt_reg <= div_cnt_next;
      tick_reg <= tick_next;
      track_cnt_reg <= track_cnt_next;
      track_done_reg <= track_done_next;
    end
  end

  assign tif.tick = tick_reg;
  assign tif.track_done = track_done_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  div_by_one_a: assert property (ce && tick_reg && tif.divider == 5'h00 && !tif.burst_src && $past(ce) ##1 ce
    |-> tick_reg) else $error("Divider of zero did not tick every cycle");
  lpo_hold_a: assert property (ce && tif.burst_src && !tif.lpo_tick |=> div_cnt_reg == $past(div_cnt_reg))
    else $error("Divider advanced without an oscillator edge in burst");
  track_load_a: assert property (ce && tif.track_go |=> track_cnt_reg == 4'(TRACK_TICKS))
    else $error("Tracking count not loaded");
  cover_burst_tick_c: cover property (tif.burst_src && tick_reg);
endmodule

/* src/sac_tick_if.sv */
/*
  Carrier between the control core and its SAR clock and tracking timer.
  Assumes both ends run on the same clock.
*/
interface sac_tick_if;
  import sac_pkg::*;
  logic burst_src;
  logic lpo_tick;
  sac_div_type divider;
  logic track_go;
  logic tick;
  logic track_done;
  modport ctrl(output burst_src, output lpo_tick, output divider, output track_go, input tick, input track_done);
  modport timer(input burst_src, input lpo_tick, input divider, input track_go, output tick, output track_done);
endinterface

/* verification/sac_core_model.sv */
/*
  Behavioural model of the analog SAR core that sits behind the converter control block.
  Assumes one core_start pulse per conversion and bit decisions clocked by sar_tick.
*/
module sac_core_model #(
  parameter int CONV_TICKS = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic core_start,
  input wire logic sar_tick,
  input wire logic slow,
  input wire sac_pkg::sac_result_type sample,
  output logic core_done,
  output sac_pkg::sac_result_type core_result
);
  timeunit 1ns;
  timeprecision 1ps;
  import sac_pkg::*;
  int ticks_reg;
  int wait_reg;
  logic busy_reg;
  sac_result_type last_reg;
  always @(posedge clk) begin
    core_done <= 1'b0;
    if (rst) begin
      busy_reg <= 1'b0;
      last_reg <= 10'h000;
    end else if (core_start) begin
      busy_reg <= 1'b1;
      ticks_reg <= 0;
      wait_reg <= slow ? 6 : 0;
    end else if (busy_reg && ticks_reg < CONV_TICKS) begin
      if (sar_tick) begin
        ticks_reg <= ticks_reg + 1;
      end
    end else if (busy_reg && wait_reg > 0) begin
      wait_reg <= wait_reg - 1;
    end else if (busy_reg) begin
      busy_reg <= 1'b0;
      core_done <= 1'b1;
      last_reg <= sample;
    end
  end
  // Result lines mean nothing outside core_done, so they show the inverse of the last result
  assign core_result = core_done ? last_reg : ~last_reg;
endmodule

/* verification/tb_top.sv */
/*
  Self-checking testbench of the converter control block with the analog core model.
  Assumes a 20 MHz system clock and register strobes driven one cycle each.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sac_pkg::*;
  logic clk, rst, ce, sfr_wr, sfr_rd, lpo_tick, lpo_run, core_done, slow;
  logic core_powered, core_start, core_track, sar_tick, eight_bit_mode, gain_select, divider_source_lpo;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, result_high_byte, result_low_byte;
  logic [3:0] trig;
  sac_result_type lower, upper, core_result, sample;
  int miscompares, samples_checked, cycles;
  sac_adc_ctrl dut (.clk(clk), .rst(rst), .ce(ce), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .timer0_overflow(trig[0]),
    .timer2_overflow(trig[1]), .timer3_overflow(trig[2]), .external_convert_pin(trig[3]),
    .lpo_tick(lpo_tick), .window_lower_bound(lower), .window_upper_bound(upper), .core_done(core_done),
    .core_result(core_result), .core_powered(core_powered), .core_start(core_start), .core_track(core_track),
    .sar_tick(sar_tick), .eight_bit_mode(eight_bit_mode), .gain_select(gain_select),
    .divider_source_lpo(divider_source_lpo), .result_high_byte(result_high_byte),
    .result_low_byte(result_low_byte));
  sac_core_model core (.clk(clk), .rst(rst), .core_start(core_start), .sar_tick(sar_tick), .slow(slow),
    .sample(sample), .core_done(core_done), .core_result(core_result));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    lpo_tick <= lpo_run && (cycles % 4 == 0);
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1;
    d = sfr_rdata;
  endtask
  task automatic pulse(input int which);
    @(posedge clk);
    trig[which] <= 1'b1;
    @(posedge clk);
    trig <= 4'h0;
  endtask
  task automatic wait_start(input int lim);
    int n;
    n = 0;
    #1;
    while (core_start !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic wait_done(input logic [15:0] res, input logic win);
    logic [7:0] d;
    int n;
    n = 0;
    while (core_done !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(core_done, 1'b1, "core finished");
    repeat (2) @(posedge clk);
    #1;
    chk({result_high_byte, result_low_byte}, res, "result bytes");
    rd(8'he8, d);
    chk(d[5], 1'b1, "done flag");
    chk(d[3], win, "window flag");
  endtask
  task automatic t_reset;
    logic [7:0] d;
    rd(8'h97, d);
    chk(d, 8'hf8, "config reset");
    rd(8'he8, d);
    chk(d, 8'h00, "control reset");
    rd(8'h55, d);
    chk(d, 8'h00, "unmapped read");
    chk({core_powered, divider_source_lpo, gain_select}, 3'h0, "reset outputs");
  endtask
  task automatic t_software;
    logic [7:0] d;
    wr(8'h97, 8'h01);
    #1;
    chk({gain_select, eight_bit_mode}, 2'h2, "gain one, ten bits");
    wr(8'he8, 8'h80);
    #1;
    chk(core_powered, 1'b1, "enabled");
    wr(8'he8, 8'h90);
    wait_start(0);
    chk({core_start, core_track}, 2'h2, "immediate start");
    wait_done({10'h2a5, 6'h00}, 1'b1);
    wr(8'he8, 8'h80);
    rd(8'he8, d);
    chk(d, 8'h80, "flags cleared");
  endtask
  task automatic t_triggers;
    logic [2:0] src[5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    int idx[5] = '{0, 1, 2, 3, 3};
    for (int k = 0; k < 5; k++) begin
      wr(8'he8, {5'h10, src[k]});
      pulse((idx[k] + 1) % 4);
      wait_start(3);
      chk(core_start, 1'b0, "foreign trigger");
      pulse(idx[k]);
      wait_start(2);
      chk(core_start, 1'b1, "selected trigger");
      wait_done({10'h2a5, 6'h00}, 1'b1);
    end
  endtask
  task automatic t_disabled;
    wr(8'he8, 8'h01);
    #1;
    chk(core_powered, 1'b0, "shut down");
    pulse(0);
    wait_start(4);
    chk(core_start, 1'b0, "timer while off");
    wr(8'he8, 8'h10);
    wait_start(4);
    chk(core_start, 1'b0, "software while off");
  endtask
  task automatic t_track;
    int ticks, cyc, last, gap;
    wr(8'h97, 8'h12); // Divider two, delayed tracking
    wr(8'he8, 8'h82); // Enabled, timer 2 overflow starts
    pulse(1);
    #1;
    chk({core_track, core_start}, 2'h2, "tracking begins");
    ticks = 0;
    cyc = 0;
    last = 0;
    gap = 0;
    while (core_start !== 1'b1 && cyc < 40) begin
      if (sar_tick === 1'b1 && core_track === 1'b1) begin
        gap = cyc - last;
        ticks++;
        last = cyc;
      end
      @(posedge clk);
      #1;
      cyc++;
    end
    chk(ticks[15:0], 16'h3, "tracking ticks");
    chk(gap[15:0], 16'h3, "tick spacing");
    wait_done({10'h2a5, 6'h00}, 1'b1);
  endtask
  task automatic t_eight;
    wr(8'he8, 8'h80);
    wr(8'h97, 8'h04);
    #1;
    chk({eight_bit_mode, gain_select}, 2'h2, "eight bits, gain half");
    sample = 10'h3ff;
    slow = 1'b1;
    wr(8'he8, 8'h90);
    wait_done(16'hff00, 1'b0);
    slow = 1'b0;
  endtask
  task automatic t_burst;
    int n;
    wr(8'he8, 8'h40);
    wr(8'h97, 8'h00);
    sample = 10'h2a5;
    wr(8'he8, 8'h50); // Starts stay at least four system clocks apart
    wait_start(2);
    chk({core_start, divider_source_lpo}, 2'h3, "burst start");
    n = 0;
    repeat (20) begin
      @(posedge clk);
      #1;
      n += (sar_tick === 1'b1);
    end
    chk(n[15:0], 16'h0, "no ticks without oscillator");
    chk(core_powered, 1'b1, "burst powered");
    lpo_run = 1'b1;
    wait_done({10'h2a5, 6'h00}, 1'b1);
    chk(core_powered, 1'b0, "burst ended");
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    {rst, ce, sfr_wr, sfr_rd, lpo_run, slow} = 6'h21;
    {sfr_addr, sfr_wdata, trig, cycles} = '0;
    ce = 1'b1;
    lower = 10'h100;
    upper = 10'h300;
    sample = 10'h2a5;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_software();
    t_triggers();
    t_disabled();
    t_track();
    t_eight();
    t_burst();
    complete_run();
  end
endmodule
